/* File: rtl/link_slot_regs.sv */
`timescale 1ns/1ps
// Functional notes
// - speed code bits 3:0, reset one
// - negotiated lane count at bits 9:4
// - training fault reported at bit 10
// - training in progress at bit 11
// - slot clock bit from straps, overridable
// - bit 13 shows data link active
// - bit 13 zero without reporting capability
// - bits 0..4 flag present hot-plug elements
// - slot fields read zero without slot
// - bit 5 marks surprise removal allowed
// - bit 6 marks hot-plug capable slot
// - writable limit value bits 14:7, reset zero
// - writable limit scale bits 16:15
// - slot register write sends limit message
// - entering DL_Up sends limit message
module link_slot_regs
   import lnk_slot_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // link and data link layer status
   input wire logic [3:0] link_speed_code,
   input wire logic [5:0] link_lane_count,
   input wire logic training_fault,
   input wire logic training_active,
   input wire logic datalink_up,
   // common clock straps
   input wire logic upstream_shared_clk_strap,
   input wire logic downstream_shared_clk_strap,
   // set slot power limit message towards the link
   input wire logic spl_msg_ack,
   output logic spl_msg_req,
   output logic [7:0] spl_msg_value,
   output logic [1:0] spl_msg_scale
);
   // -------------------------------------------------
   // status inputs into the core domain
   // -------------------------------------------------
   logic [3:0] speed_s;
   logic [5:0] lanes_s;
   logic tfault_s;
   logic tactive_s;
   logic dlup_s;
   logic us_strap_s;
   logic ds_strap_s;

   // all status pins are asynchronous to core_clk
   pin_sync #(.W(4)) u_sync_speed (
      .core_clk(core_clk),
      .reset(reset),
      .din(link_speed_code),
      .dout(speed_s)
   );

   pin_sync #(.W(6)) u_sync_lanes (
      .core_clk(core_clk),
      .reset(reset),
      .din(link_lane_count),
      .dout(lanes_s)
   );

   // training, link and strap bits share one synchroniser
   pin_sync #(.W(5)) u_sync_bits (
      .core_clk(core_clk),
      .reset(reset),
      .din({training_fault, training_active, datalink_up,
            upstream_shared_clk_strap, downstream_shared_clk_strap}),
      .dout({tfault_s, tactive_s, dlup_s, us_strap_s, ds_strap_s})
   );

   // -------------------------------------------------
   // bus address phase decode
   // -------------------------------------------------
   logic addr_phase;
   logic hit_lsts;
   logic hit_scap;
   logic hit_cfg;
   logic wr_q;
   logic [2:0] sel_q;

   // a transfer is taken only while the bus is ready
   assign addr_phase = hsel && htrans[HTRANS_ACT_BIT] && hready;
   assign hit_lsts = haddr == LSTS_ADDR;
   assign hit_scap = haddr == SCAP_ADDR;
   assign hit_cfg = haddr == CFG_ADDR;

   // remember which register a write will land in
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wr_q <= 1'b0;
         sel_q <= 3'h0;
      end else begin
         wr_q <= addr_phase && hwrite;
         sel_q <= addr_phase ? {hit_cfg, hit_scap, hit_lsts} : 3'h0;
      end
   end

   // -------------------------------------------------
   // data phase write strobes
   // -------------------------------------------------
   logic wr_lsts;
   logic wr_scap;
   logic wr_cfg;

   // strobes stand for the whole data phase
   assign wr_lsts = wr_q && sel_q[0];
   assign wr_scap = wr_q && sel_q[1];
   assign wr_cfg = wr_q && sel_q[2];

   // -------------------------------------------------
   // port configuration register
   // -------------------------------------------------
   logic [2:0] cfg_q;
   logic slot_impl;
   logic dlrep_cap;
   logic upstream;

   // slot and reporting capability bits stand in for the
   // port and link capability registers held elsewhere
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cfg_q <= CFG_RST;
      end else if (wr_cfg) begin
         cfg_q <= hwdata[2:0];
      end
   end

   // named views of the configuration bits
   assign slot_impl = cfg_q[CFG_SLOT_BIT];
   assign dlrep_cap = cfg_q[CFG_DLREP_BIT];
   assign upstream = cfg_q[CFG_UPSTREAM_BIT];

   // -------------------------------------------------
   // link state report
   // -------------------------------------------------
   logic [3:0] speed_q;
   logic [5:0] lanes_q;
   logic tfault_q;
   logic tactive_q;
   logic dlup_q;
   logic dlup_prev_q;
   logic [1:0] settle_q;
   logic sync_full;
   logic strap_sel;
   logic sclk_sw_q;
   logic sclk_own_q;
   logic slot_clk;

   // the synchronisers read zero until they have filled, so
   // the speed field keeps its reset code until then
   assign sync_full = settle_q == STRAP_SETTLE;

   // the right strap depends on port direction
   assign strap_sel = upstream ? us_strap_s : ds_strap_s;

   // status registers track the synchronised inputs
   always_ff @(posedge core_clk) begin
      if (reset) begin
         speed_q <= SPEED_RST;
         lanes_q <= 6'h00;
         tfault_q <= 1'b0;
         tactive_q <= 1'b0;
         dlup_q <= 1'b0;
         dlup_prev_q <= 1'b0;
      end else begin
         speed_q <= sync_full ? speed_s : SPEED_RST;
         lanes_q <= lanes_s;
         tfault_q <= tfault_s;
         tactive_q <= tactive_s;
         dlup_q <= dlup_s;
         dlup_prev_q <= dlup_q;
      end
   end

   // count the edges the synchronisers need after reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         settle_q <= 2'h0;
      end else if (!sync_full) begin
         settle_q <= settle_q + 2'h1;
      end
   end

   // a software write (eeprom load) takes the bit over
   // from the strap and keeps it until the next reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sclk_sw_q <= 1'b0;
         sclk_own_q <= 1'b0;
      end else if (wr_lsts) begin
         sclk_sw_q <= hwdata[SLOTCLK_BIT];
         sclk_own_q <= 1'b1;
      end
   end

   // the strap is followed live rather than latched once:
   // port direction is configured after reset, and a latch
   // would always see the downstream strap
   assign slot_clk = sclk_own_q ? sclk_sw_q : strap_sel;

   logic dlup_rep;
   logic [15:0] lsts_val;

   // reporting capability gates the active bit
   assign dlup_rep = dlup_q && dlrep_cap;

   // each field sits at its own position, top bits read zero
   assign lsts_val[SPEED_LSB +: 4] = speed_q;
   assign lsts_val[WIDTH_LSB +: 6] = lanes_q;
   assign lsts_val[TFAULT_BIT] = tfault_q;
   assign lsts_val[TACTIVE_BIT] = tactive_q;
   assign lsts_val[SLOTCLK_BIT] = slot_clk;
   assign lsts_val[DLUP_BIT] = dlup_rep;
   assign lsts_val[15:14] = 2'b00;

   // -------------------------------------------------
   // slot feature report
   // -------------------------------------------------
   logic [6:0] present_q;
   logic [7:0] plv_q;
   logic [1:0] pls_q;

   // writes are dropped while no slot is implemented
   always_ff @(posedge core_clk) begin
      if (reset) begin
         present_q <= PRESENT_RST;
         plv_q <= PLV_RST;
         pls_q <= PLS_RST;
      end else if (wr_scap && slot_impl) begin
         present_q <= hwdata[PRESENT_LSB +: PRESENT_W];
         plv_q <= hwdata[PLV_LSB +: 8];
         pls_q <= hwdata[PLS_LSB +: 2];
      end
   end

   logic [6:0] present_rd;
   logic [7:0] plv_rd;
   logic [1:0] pls_rd;
   logic [31:0] scap_val;
   logic attn_button_present;
   logic power_ctrl_present;
   logic latch_sensor_present;
   logic attn_lamp_present;
   logic power_lamp_present;
   logic surprise_removal;
   logic hotplug_able;

   // without a slot every field reads as zero
   assign present_rd = slot_impl ? present_q : 7'h00;
   assign plv_rd = slot_impl ? plv_q : 8'h00;
   assign pls_rd = slot_impl ? pls_q : 2'h0;

   // one named wire per hot-plug element, lowest bit last
   assign {hotplug_able, surprise_removal, power_lamp_present, attn_lamp_present,
           latch_sensor_present, power_ctrl_present, attn_button_present} = present_rd;

   // fields placed by position, the rest reads zero here
   assign scap_val[PRESENT_LSB +: PRESENT_W] = {hotplug_able, surprise_removal,
      power_lamp_present, attn_lamp_present, latch_sensor_present, power_ctrl_present,
      attn_button_present};
   assign scap_val[PLV_LSB +: 8] = plv_rd;
   assign scap_val[PLS_LSB +: 2] = pls_rd;
   assign scap_val[PLS_LSB + 2 +: 15] = 15'h0000;

   // -------------------------------------------------
   // power limit message triggers
   // -------------------------------------------------
   logic dl_enter;
   logic msg_trig_q;

   // entry uses the raw state: a port without the reporting
   // capability still announces its limit to the partner
   assign dl_enter = dlup_q && !dlup_prev_q;

   // delayed one cycle so the message sees the new limit
   always_ff @(posedge core_clk) begin
      if (reset) begin
         msg_trig_q <= 1'b0;
      end else begin
         msg_trig_q <= wr_scap || dl_enter;
      end
   end

   spl_msg_req u_msg (
      .core_clk(core_clk),
      .reset(reset),
      .trig(msg_trig_q),
      .value(plv_rd),
      .scale(pls_rd),
      .msg_ack(spl_msg_ack),
      .msg_req(spl_msg_req),
      .msg_value(spl_msg_value),
      .msg_scale(spl_msg_scale)
   );

   // -------------------------------------------------
   // read data and response
   // -------------------------------------------------
   logic [31:0] rd_mux;
   logic [31:0] rdata_q;
   logic readyout_q;
   logic resp_q;

   // unmapped words read zero, answer is always okay
   // the mux looks at the live address phase, not a stored one
   assign rd_mux = hit_lsts ? {16'h0000, lsts_val} :
                   hit_scap ? scap_val :
                   hit_cfg ? {29'h00000000, cfg_q} : 32'h00000000;

   // read data is fetched in the address phase so it
   // leaves a flop during the data phase, no wait state
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdata_q <= 32'h00000000;
         readyout_q <= 1'b1;
         resp_q <= 1'b0;
      end else begin
         if (addr_phase && !hwrite) begin
            rdata_q <= rd_mux;
         end
         readyout_q <= 1'b1;
         resp_q <= 1'b0;
      end
   end

   // bus outputs straight from their flops
   assign hrdata = rdata_q;
   assign hreadyout = readyout_q;
   assign hresp = resp_q;
endmodule

/* File: rtl/lnk_slot_pkg.sv */
package lnk_slot_pkg;
   // -------------------------------------------------
   // register indices and byte addresses
   // -------------------------------------------------
   localparam logic [11:0] LSTS_IDX = 12'h052;
   localparam logic [11:0] SCAP_IDX = 12'h054;
   localparam logic [11:0] CFG_IDX = 12'h056;
   localparam logic [11:0] LSTS_ADDR = 12'h148;
   localparam logic [11:0] SCAP_ADDR = 12'h150;
   localparam logic [11:0] CFG_ADDR = 12'h158;

   // -------------------------------------------------
   // link state report fields
   // -------------------------------------------------
   localparam int SPEED_LSB = 0;
   localparam int WIDTH_LSB = 4;
   localparam int TFAULT_BIT = 10;
   localparam int TACTIVE_BIT = 11;
   localparam int SLOTCLK_BIT = 12;
   localparam int DLUP_BIT = 13;
   localparam logic [3:0] SPEED_RST = 4'h1;
   localparam logic [3:0] SPEED_GEN1 = 4'h1;
   localparam logic [3:0] SPEED_GEN2 = 4'h2;

   // -------------------------------------------------
   // slot feature report fields
   // -------------------------------------------------
   localparam int PRESENT_LSB = 0;
   localparam int PRESENT_W = 7;
   localparam int PLV_LSB = 7;
   localparam int PLS_LSB = 15;
   localparam logic [6:0] PRESENT_RST = 7'h00;
   localparam logic [7:0] PLV_RST = 8'h00;
   localparam logic [1:0] PLS_RST = 2'h0;

   // -------------------------------------------------
   // port configuration register fields
   // -------------------------------------------------
   localparam int CFG_SLOT_BIT = 0;
   localparam int CFG_DLREP_BIT = 1;
   localparam int CFG_UPSTREAM_BIT = 2;
   localparam logic [2:0] CFG_RST = 3'h0;

   // cycles after reset release before the speed code is taken
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // ahb transfer type bit that marks an active transfer
   localparam int HTRANS_ACT_BIT = 1;
endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps
// -------------------------------------------------
// two flop synchroniser, first stage read only here
// -------------------------------------------------
module pin_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] stab_q;

   // both stages clear on reset, values come later
   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta_q <= '0;
         stab_q <= '0;
      end else begin
         meta_q <= din;
         stab_q <= meta_q;
      end
   end

   assign dout = stab_q;
endmodule

/* File: rtl/spl_msg_req.sv */
`timescale 1ns/1ps
// -------------------------------------------------
// power limit message request holder
// -------------------------------------------------
module spl_msg_req (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic trig,
   input wire logic [7:0] value,
   input wire logic [1:0] scale,
   input wire logic msg_ack,
   output logic msg_req,
   output logic [7:0] msg_value,
   output logic [1:0] msg_scale
);
   logic pend_q;
   logic pend_d;
   logic req_q;
   logic [7:0] val_q;
   logic [1:0] scl_q;

   // a new trigger beats the ack so no message is lost
   assign pend_d = trig ? 1'b1 : ((req_q && msg_ack) ? 1'b0 : pend_q);

   // payload is refreshed on every trigger, newest limit wins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pend_q <= 1'b0;
         req_q <= 1'b0;
         val_q <= 8'h00;
         scl_q <= 2'h0;
      end else begin
         pend_q <= pend_d;
         req_q <= pend_d;
         if (trig) begin
            val_q <= value;
            scl_q <= scale;
         end
      end
   end

   assign msg_req = req_q;
   assign msg_value = val_q;
   assign msg_scale = scl_q;
endmodule

/* File: sim/link_slot_regs_sva.sv */
`timescale 1ns/1ps
module link_slot_regs_sva
   import lnk_slot_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic [3:0] link_speed_code,
   input wire logic [5:0] link_lane_count,
   input wire logic training_fault,
   input wire logic training_active,
   input wire logic datalink_up,
   input wire logic spl_msg_ack,
   input wire logic spl_msg_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // -------------------------------------------------
   // taken transfers and status age
   // -------------------------------------------------
   wire logic take = hsel && htrans[HTRANS_ACT_BIT] && hready;
   wire logic rd = take && !hwrite;
   wire logic [11:0] stat = {training_active, training_fault, link_lane_count, link_speed_code};
   wire logic mapped = haddr inside {LSTS_ADDR, SCAP_ADDR, CFG_ADDR};
   logic [2:0] quiet_q;
   // sync path is three flops deep, reads three edges after a change are settled
   always_ff @(posedge core_clk) begin
      if (reset || !$stable(stat)) quiet_q <= 3'h0;
      else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
   end
   a_ready_high: assert property (hreadyout) else $error("wait state seen");
   a_resp_okay: assert property (!hresp) else $error("error response seen");
   a_status_read:
      assert property (rd && haddr == LSTS_ADDR && quiet_q >= 3'h3
         |=> hrdata[11:0] == $past(stat)) else $error("status read wrong");
   a_upper_zero: assert property (rd && haddr == LSTS_ADDR |=> hrdata[31:14] == 18'h0)
      else $error("link report upper bits set");
   a_unmapped_zero: assert property (rd && !mapped |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_req_holds:
      assert property (spl_msg_req && !spl_msg_ack |=> spl_msg_req) else $error("req dropped");
   a_write_msg:
      assert property (take && hwrite && haddr == SCAP_ADDR |-> ##[1:6] spl_msg_req)
      else $error("no message after write");
   a_dlup_msg:
      assert property ($rose(datalink_up) |-> ##[1:10] spl_msg_req) else $error("no dl message");
   c_msg_taken: cover property (spl_msg_req && spl_msg_ack);
   c_slot_read: cover property (rd && haddr == SCAP_ADDR);
   c_dl_rise: cover property ($rose(datalink_up));
endmodule
bind link_slot_regs link_slot_regs_sva u_sva (.*);

/* File: sim/spl_sink.sv */
`timescale 1ns/1ps
// -------------------------------------------------
// link partner taking power limit messages
// -------------------------------------------------
module spl_sink (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic spl_msg_req,
   input wire logic [7:0] spl_msg_value,
   input wire logic [1:0] spl_msg_scale,
   input wire logic slow,
   output logic spl_msg_ack,
   output int count,
   output logic [9:0] last
);
   logic [1:0] wait_q;
   // slow mode stalls three cycles, like a busy partner
   always @(posedge core_clk) begin
      if (reset) begin
         spl_msg_ack <= 1'b0;
         count <= 0;
         last <= 10'h0;
         wait_q <= 2'h0;
      end else begin
         spl_msg_ack <= 1'b0;
         if (spl_msg_req && !spl_msg_ack && wait_q != 2'h0) wait_q <= wait_q - 2'h1;
         else if (spl_msg_req && !spl_msg_ack) begin
            spl_msg_ack <= 1'b1;
            count <= count + 1;
            last <= {spl_msg_scale, spl_msg_value};
         end else wait_q <= slow ? 2'h3 : 2'h0;
      end
   end
endmodule

/* File: sim/link_slot_regs_test.sv */
`timescale 1ns/1ps
module link_slot_regs_test
   import lnk_slot_pkg::*;
;
   logic core_clk = 0;
   logic reset = 1;
   logic hsel, hwrite, hreadyout, hresp, training_fault, training_active, datalink_up;
   logic upstream_shared_clk_strap, downstream_shared_clk_strap, spl_msg_ack, spl_msg_req, slow;
   logic [11:0] haddr;
   logic [1:0] htrans, spl_msg_scale;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, r, w;
   logic [3:0] link_speed_code;
   logic [5:0] link_lane_count;
   logic [7:0] spl_msg_value;
   logic [9:0] last;
   int bad_count = 0;
   int n_tests = 0;
   int count;
   wire logic hready = hreadyout;
   always #50 core_clk = ~core_clk;
   link_slot_regs u_link_slot_regs (.*);
   spl_sink u_spl_sink (.*);
   // -------------------------------------------------
   // bus and compare helpers
   // -------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // master never assumes a latency, only ready or the bound ends a wait
   task automatic hwait;
      int n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         bad_count++;
         results();
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hwait();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hwait();
      r = hrdata;
   endtask
   task automatic msg(input int n, input logic [9:0] e);
      int k = 0;
      while (count != n && k < 40) begin
         @(posedge core_clk);
         k++;
      end
      chk(count, n);
      chk(last, e);
   endtask
   function automatic logic [31:0] lsts(input logic sclk, input logic dlb);
      return {18'h0, dlb, sclk, training_active, training_fault, link_lane_count, link_speed_code};
   endfunction
   initial begin
      #5000000;
      bad_count++;
      results();
   end
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, link_lane_count, slow} = '0;
      {training_fault, training_active, datalink_up, upstream_shared_clk_strap} = '0;
      hsize = 3'h2;
      link_speed_code = 4'h1;
      downstream_shared_clk_strap = 1'b1;
      void'($urandom(32'h6a11552f));
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      repeat (4) @(posedge core_clk);
      bus(0, LSTS_ADDR, 0);
      chk(r, 32'h1001);
      bus(0, SCAP_ADDR, 0);
      chk(r, 0);
      bus(0, 12'h15c, 0);
      chk(r, 0);
      $display("reset values done");
      repeat (8) begin
         link_speed_code <= $urandom_range(1) ? SPEED_GEN2 : SPEED_GEN1;
         link_lane_count <= 6'($urandom_range(63));
         training_fault <= 1'($urandom_range(1));
         training_active <= 1'($urandom_range(1));
         repeat (4) @(posedge core_clk);
         bus(0, LSTS_ADDR, 0);
         chk(r, lsts(1'b1, 1'b0));
      end
      $display("status done");
      // no slot: nothing stored, message still goes out empty
      bus(1, SCAP_ADDR, 32'h1ffff);
      bus(0, SCAP_ADDR, 0);
      chk(r, 0);
      msg(1, 10'h0);
      bus(1, CFG_ADDR, 32'h3);
      for (int s = 0; s < 4; s++) begin
         w = {15'h0, 2'(s), 8'($urandom), 7'($urandom)};
         slow <= s[0];
         bus(1, SCAP_ADDR, w);
         bus(0, SCAP_ADDR, 0);
         chk(r, w);
         msg(2 + s, w[16:7]);
      end
      $display("slot writes done");
      datalink_up <= 1'b1;
      msg(6, w[16:7]);
      bus(0, LSTS_ADDR, 0);
      chk(r[13], 1);
      bus(1, CFG_ADDR, 32'h1);
      bus(0, LSTS_ADDR, 0);
      chk(r[13], 0);
      bus(1, CFG_ADDR, 32'h5);
      bus(0, LSTS_ADDR, 0);
      chk(r[12], 0);
      bus(1, CFG_ADDR, 32'h1);
      bus(1, LSTS_ADDR, 32'h0);
      bus(0, LSTS_ADDR, 0);
      chk(r[12], 0);
      $display("link events done");
      results();
   end
endmodule
